// [rtl/rcsu_remote_command_status_unit.v]
/*
  remote command and status unit: apb slave holding the common status
  model (status byte, event register, masks, error groups) and the
  instrument configuration set by remote commands.
  assumes a front end that parses text, flags the terminator on cmd_term_seen and
  hands one decoded command with binary arguments at a time; strings
  and decimal formatting are done by that front end.
*/
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "rcsu_consts.vh"

module rcsu_remote_command_status_unit #(
  parameter        SERIAL_NUM = 32'h0000_0001, // arbitrary value
  parameter        MAKER_CODE = 8'h5A,         // arbitrary value
  parameter        MODEL_CODE = 8'h01,         // arbitrary value
  parameter        FW_MAIN    = 8'h10,
  parameter        FW_CONV    = 8'h10,
  parameter        ERR_W      = 8
) (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // instrument side
  input  wire              cmd_term_seen,
  input  wire              ops_busy,
  input  wire              selftest_fail,
  input  wire              key_pressed,
  input  wire              output_at_zero,
  input  wire [15:0]       meas_current,
  input  wire [ERR_W-1:0]  hw_err_det,
  input  wire [ERR_W-1:0]  op_err_det,
  input  wire [ERR_W-1:0]  heat_err_det,
  input  wire [ERR_W-1:0]  op_err_cond,
  input  wire [ERR_W-1:0]  heat_err_cond,
  input  wire [7:0]        event_det,
  // outputs to the instrument
  output reg               srq,
  output reg               trigger_pulse,
  output reg               abort_pulse,
  output reg               inst_reset_pulse,
  output reg  [1:0]        baud_code,
  output reg  [16:0]       baud_rate,
  output reg  [3:0]        screen_setup,
  output reg  [1:0]        bus_term,
  output reg               bus_eoi_off,
  output reg  [4:0]        bus_addr,
  output reg               field_units,
  output reg  [31:0]       field_value
);

  // ==========================================================
  // state
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;

  reg  [1:0]        state;
  reg  [7:0]        cmd_code;
  reg               cmd_valid;
  reg  [31:0]       arg;
  reg  [31:0]       resp;
  reg               resp_valid;
  reg  [7:0]        esr;
  reg  [7:0]        ese;
  reg  [7:0]        sre;
  reg  [7:0]        stb_low;
  reg  [ERR_W-1:0]  err_hw;
  reg  [ERR_W-1:0]  err_op;
  reg  [ERR_W-1:0]  err_ht;
  reg  [ERR_W-1:0]  msk_hw;
  reg  [ERR_W-1:0]  msk_op;
  reg  [ERR_W-1:0]  msk_ht;
  reg  [15:0]       fconst;
  reg               key_flag;
  reg               opc_armed;
  reg               opcq_wait;
  reg  [1:0]        pend_term;
  reg               pend_term_v;
  reg               selftest_res;
  reg               st_captured;

  // ==========================================================
  // functions
  function [16:0] baud_of;
    input [1:0] code;
    begin
      case (code)
        2'd0:    baud_of = 17'd9600;
        2'd1:    baud_of = 17'd19200;
        2'd2:    baud_of = 17'd38400;
        default: baud_of = 17'd57600;
      endcase
    end
  endfunction

  function [31:0] err_pack;
    input [ERR_W-1:0] a;
    input [ERR_W-1:0] b;
    input [ERR_W-1:0] c;
    begin
      err_pack = {8'h00, a, b, c};
    end
  endfunction

  // ==========================================================
  // status byte composition
  wire       esb_sum  = |(esr & ese);
  wire       err_sum  = |(err_hw & msk_hw) | |(err_op & msk_op)
                        | |(err_ht & msk_ht);
  wire [7:0] stb_base = {2'b00, esb_sum, 2'b00, err_sum, 2'b00}
                        | (stb_low & 8'hBF);
  wire       rqs      = |(stb_base & sre & 8'hBF);
  wire [7:0] stb_val  = {stb_base[7], rqs, stb_base[5:0]};

  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire esr_rd = apb_rd & (paddr == `RCSU_OFF_ESR);
  wire err_rd = apb_rd & (paddr == `RCSU_OFF_ERRST);

  // ==========================================================
  // apb read path and acceptance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        if (paddr == `RCSU_OFF_STAT)
          prdata <= {29'h0, opcq_wait, resp_valid, cmd_valid};
        else if (paddr == `RCSU_OFF_RESP)
          prdata <= resp;
        else if (paddr == `RCSU_OFF_STB)
          prdata <= {24'h0, stb_val};
        else if (paddr == `RCSU_OFF_ESR)
          prdata <= {24'h0, esr};
        else if (paddr == `RCSU_OFF_ERRST)
          prdata <= err_pack(err_hw, err_op, err_ht);
        else if (paddr == `RCSU_OFF_ERRMASK)
          prdata <= err_pack(msk_hw, msk_op, msk_ht);
        else if (paddr == `RCSU_OFF_FIELD)
          prdata <= field_value;
        else if (paddr == `RCSU_OFF_CFG)
          prdata <= {1'b0, field_units, bus_addr, bus_eoi_off, bus_term,
                     screen_setup, baud_code, sre, ese};
        else if (paddr == `RCSU_OFF_IDN)
          prdata <= {MAKER_CODE[7:0], MODEL_CODE[7:0], FW_MAIN[7:0],
                     FW_CONV[7:0]};
        else if ((paddr != `RCSU_OFF_CMD) && (paddr != `RCSU_OFF_ARG))
          pslverr <= 1'b1;
      end else if (psel & ~penable & pwrite) begin
        if ((paddr != `RCSU_OFF_CMD) && (paddr != `RCSU_OFF_ARG))
          pslverr <= 1'b1;
      end
    end
  end

  // ==========================================================
  // command execution
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ST_IDLE;
      cmd_code         <= 8'h00;
      cmd_valid        <= 1'b0;
      arg              <= 32'h0000_0000;
      resp             <= 32'h0000_0000;
      resp_valid       <= 1'b0;
      esr              <= 8'h00;
      ese              <= 8'h00;
      sre              <= 8'h00;
      stb_low          <= 8'h00;
      err_hw           <= {ERR_W{1'b0}};
      err_op           <= {ERR_W{1'b0}};
      err_ht           <= {ERR_W{1'b0}};
      msk_hw           <= {ERR_W{1'b0}};
      msk_op           <= {ERR_W{1'b0}};
      msk_ht           <= {ERR_W{1'b0}};
      fconst           <= `RCSU_PWR_FCONST;
      field_units      <= `RCSU_PWR_FUNITS;
      key_flag         <= 1'b1;
      opc_armed        <= 1'b0;
      opcq_wait        <= 1'b0;
      pend_term        <= `RCSU_PWR_TERM;
      pend_term_v      <= 1'b0;
      selftest_res     <= 1'b0;
      st_captured      <= 1'b0;
      srq              <= 1'b0;
      trigger_pulse    <= 1'b0;
      abort_pulse      <= 1'b0;
      inst_reset_pulse <= 1'b0;
      baud_code        <= `RCSU_PWR_BAUD;
      baud_rate        <= `RCSU_PWR_RATE;
      screen_setup     <= `RCSU_PWR_SCREEN_SETUP_CMD;
      bus_term         <= `RCSU_PWR_TERM;
      bus_eoi_off      <= `RCSU_EOI_ON;
      bus_addr         <= `RCSU_PWR_ADDR;
      field_value      <= 32'h0000_0000;
    end else begin
      trigger_pulse    <= 1'b0;
      abort_pulse      <= 1'b0;
      inst_reset_pulse <= 1'b0;
      srq              <= rqs;
      baud_rate        <= baud_of(baud_code);
      field_value      <= meas_current * fconst;
      // strap-like capture of the power-up test after release
      if (!st_captured) begin
        selftest_res <= selftest_fail;
        st_captured  <= 1'b1;
      end
      // host interface
      if (apb_wr && (paddr == `RCSU_OFF_ARG))
        arg <= pwdata;
      if (apb_wr && (paddr == `RCSU_OFF_CMD)) begin
        cmd_code  <= pwdata[7:0];
        cmd_valid <= 1'b1;
      end
      if (apb_rd && (paddr == `RCSU_OFF_RESP))
        resp_valid <= 1'b0;
      // latching sources; set beats the read-clear in the same cycle
      esr    <= (esr_rd ? 8'h00 : esr) | event_det;
      err_hw <= (err_rd ? {ERR_W{1'b0}} : err_hw) | hw_err_det;
      err_op <= (err_rd ? {ERR_W{1'b0}} : err_op) | op_err_det;
      err_ht <= (err_rd ? {ERR_W{1'b0}} : err_ht) | heat_err_det;
      if (key_pressed)
        key_flag <= 1'b1;
      if (opcq_wait && !ops_busy) begin
        resp       <= 32'h0000_0001;
        resp_valid <= 1'b1;
        opcq_wait  <= 1'b0;
      end
      if (pend_term_v && cmd_term_seen) begin
        bus_term    <= pend_term;
        pend_term_v <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_valid && cmd_term_seen) begin
            cmd_valid <= 1'b0;
            state     <= ST_WAIT;
            case (cmd_code)
              `RCSU_C_CLS: begin
                esr       <= event_det;
                stb_low   <= 8'h00;
                opc_armed <= 1'b0;
                opcq_wait <= 1'b0;
                abort_pulse <= 1'b1;
              end
              `RCSU_C_ESE:  ese <= arg[7:0];
              `RCSU_C_ESEQ: begin resp <= {24'h0, ese}; resp_valid <= 1'b1; end
              `RCSU_C_ESRQ: begin
                resp       <= {24'h0, esr};
                resp_valid <= 1'b1;
                esr        <= event_det;
              end
              `RCSU_C_IDNQ: begin
                resp       <= SERIAL_NUM;
                resp_valid <= 1'b1;
              end
              `RCSU_C_OPC:  opc_armed <= 1'b1;
              `RCSU_C_OPCQ: opcq_wait <= 1'b1;
              `RCSU_C_RST: begin
                baud_code        <= `RCSU_PWR_BAUD;
                screen_setup     <= `RCSU_PWR_SCREEN_SETUP_CMD;
                fconst           <= `RCSU_PWR_FCONST;
                field_units      <= `RCSU_PWR_FUNITS;
                inst_reset_pulse <= 1'b1;
              end
              `RCSU_C_SRE:  sre <= arg[7:0] & 8'hBF;
              `RCSU_C_SREQ: begin resp <= {24'h0, sre}; resp_valid <= 1'b1; end
              `RCSU_C_STBQ: begin
                resp       <= {24'h0, stb_val};
                resp_valid <= 1'b1;
              end
              `RCSU_C_TRG:  trigger_pulse <= 1'b1;
              `RCSU_C_TSTQ: begin
                resp       <= {31'h0, selftest_res};
                resp_valid <= 1'b1;
              end
              `RCSU_C_BAUD: baud_code <= arg[1:0];
              `RCSU_C_BAUDQ: begin resp <= {30'h0, baud_code}; resp_valid <= 1'b1; end
              `RCSU_C_FACTORY_RESTORE_CMD: begin
                if ((arg[7:0] == `RCSU_FACTORY_RESTORE_CMD_KEY) && output_at_zero) begin
                  baud_code        <= `RCSU_PWR_BAUD;
                  screen_setup     <= `RCSU_PWR_SCREEN_SETUP_CMD;
                  fconst           <= `RCSU_PWR_FCONST;
                  field_units      <= `RCSU_PWR_FUNITS;
                  bus_addr         <= `RCSU_PWR_ADDR;
                  bus_eoi_off      <= `RCSU_EOI_ON;
                  pend_term        <= `RCSU_PWR_TERM;
                  pend_term_v      <= 1'b1;
                  ese              <= 8'h00;
                  sre              <= 8'h00;
                  inst_reset_pulse <= 1'b1;
                end else
                  esr[`RCSU_ESR_CMDERR] <= 1'b1;
              end
              `RCSU_C_SCREEN_SETUP_CMD: screen_setup <= arg[3:0];
              `RCSU_C_DISPQ: begin resp <= {28'h0, screen_setup}; resp_valid <= 1'b1; end
              `RCSU_C_ERROR_CLEAR_CMD: begin
                err_op <= (err_op & op_err_cond) | op_err_det;
                err_ht <= (err_ht & heat_err_cond) | heat_err_det;
              end
              `RCSU_C_ERSTQ: begin
                resp <= err_pack(err_hw, err_op, err_ht);
                resp_valid <= 1'b1;
              end
              `RCSU_C_ERROR_MASK_CMD: begin
                msk_hw <= arg[3*ERR_W-1:2*ERR_W];
                msk_op <= arg[2*ERR_W-1:ERR_W];
                msk_ht <= arg[ERR_W-1:0];
              end
              `RCSU_C_ERSTEQ: begin
                resp <= err_pack(msk_hw, msk_op, msk_ht);
                resp_valid <= 1'b1;
              end
              `RCSU_C_ERSTRQ: begin
                resp       <= err_pack(err_hw, err_op, err_ht);
                resp_valid <= 1'b1;
                err_hw     <= hw_err_det;
                err_op     <= op_err_det;
                err_ht     <= heat_err_det;
              end
              `RCSU_C_FIELD_CONSTANT_CMD: begin
                field_units <= arg[16];
                fconst      <= arg[15:0];
              end
              `RCSU_C_FLDSQ: begin
                resp <= {15'h0, field_units, fconst};
                resp_valid <= 1'b1;
              end
              `RCSU_C_BUS: begin
                // terminator waits for the end of this command
                pend_term   <= arg[9:8];
                pend_term_v <= 1'b1;
                bus_eoi_off <= arg[4];
                if ((arg[20:16] >= `RCSU_ADDR_MIN) &&
                    (arg[20:16] <= `RCSU_ADDR_MAX))
                  bus_addr <= arg[20:16];
                else
                  esr[`RCSU_ESR_CMDERR] <= 1'b1;
              end
              `RCSU_C_BUSQ: begin
                resp <= {11'h0, bus_addr, 6'h0, bus_term, 3'h0, bus_eoi_off, 4'h0};
                resp_valid <= 1'b1;
              end
              `RCSU_C_KEYQ: begin
                resp       <= {31'h0, key_flag};
                resp_valid <= 1'b1;
                key_flag   <= key_pressed;
              end
              default: esr[`RCSU_ESR_CMDERR] <= 1'b1;
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (opc_armed && !ops_busy) begin
        esr[`RCSU_ESR_OPC] <= 1'b1;
        opc_armed          <= 1'b0;
      end
    end
  end

endmodule // rcsu_remote_command_status_unit

// [rtl/rcsu_consts.vh]
/*
  constants for the remote command and status unit: register offsets,
  field layouts, reset values and command codes.
  assumes inclusion by bare name from the design file.
*/
`ifndef RCSU_CONSTS_VH
`define RCSU_CONSTS_VH

// ==========================================================
// register byte offsets
`define RCSU_OFF_CMD      12'h000
`define RCSU_OFF_ARG      12'h004
`define RCSU_OFF_STAT     12'h008
`define RCSU_OFF_RESP     12'h00C
`define RCSU_OFF_STB      12'h010
`define RCSU_OFF_ESR      12'h014
`define RCSU_OFF_CFG      12'h018
`define RCSU_OFF_ERRST    12'h01C
`define RCSU_OFF_ERRMASK  12'h020
`define RCSU_OFF_FIELD    12'h024
`define RCSU_OFF_IDN      12'h028

// ==========================================================
// command codes written to the command register
`define RCSU_C_CLS        8'h01
`define RCSU_C_ESE        8'h02
`define RCSU_C_ESEQ       8'h03
`define RCSU_C_ESRQ       8'h04
`define RCSU_C_IDNQ       8'h05
`define RCSU_C_OPC        8'h06
`define RCSU_C_OPCQ       8'h07
`define RCSU_C_RST        8'h08
`define RCSU_C_SRE        8'h09
`define RCSU_C_SREQ       8'h0A
`define RCSU_C_STBQ       8'h0B
`define RCSU_C_TRG        8'h0C
`define RCSU_C_TSTQ       8'h0D
`define RCSU_C_BAUD       8'h10
`define RCSU_C_BAUDQ      8'h11
`define RCSU_C_FACTORY_RESTORE_CMD       8'h12
`define RCSU_C_SCREEN_SETUP_CMD       8'h13
`define RCSU_C_DISPQ      8'h14
`define RCSU_C_ERROR_CLEAR_CMD       8'h15
`define RCSU_C_ERSTQ      8'h16
`define RCSU_C_ERROR_MASK_CMD      8'h17
`define RCSU_C_ERSTEQ     8'h18
`define RCSU_C_ERSTRQ     8'h19
`define RCSU_C_FIELD_CONSTANT_CMD       8'h1A
`define RCSU_C_FLDSQ      8'h1B
`define RCSU_C_BUS        8'h1C
`define RCSU_C_BUSQ       8'h1D
`define RCSU_C_KEYQ       8'h1E

// ==========================================================
// field positions and values
`define RCSU_ESR_OPC      0
`define RCSU_ESR_CMDERR   5
`define RCSU_STB_ERRSUM   2
`define RCSU_STB_ESB      5
`define RCSU_STB_RQS      6
`define RCSU_FACTORY_RESTORE_CMD_KEY     8'h63
`define RCSU_ADDR_MIN     5'h01
`define RCSU_ADDR_MAX     5'h1E
`define RCSU_TERM_NONE    2'h3
`define RCSU_EOI_ON       1'b0
`define RCSU_PWR_BAUD     2'h0
`define RCSU_PWR_RATE     17'h0_2580
`define RCSU_PWR_SCREEN_SETUP_CMD     4'h0
`define RCSU_PWR_TERM     2'h0
`define RCSU_PWR_ADDR     5'h0C
`define RCSU_PWR_FUNITS   1'b0
`define RCSU_PWR_FCONST   16'h0064
`define RCSU_FCONST_FRAC  10

`endif

// [test/rcsu_checker.sv]
/*
  concurrent checks on the remote command and status unit ports.
  assumes a bind onto the design top and one clock domain on pclk.
*/
`timescale 1ns/100ps
module rcsu_checker (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // instrument
  input wire        cmd_term_seen,
  input wire        output_at_zero,
  input wire        trigger_pulse,
  input wire        abort_pulse,
  input wire        inst_reset_pulse,
  input wire [1:0]  baud_code,
  input wire [16:0] baud_rate,
  input wire [1:0]  bus_term,
  input wire [4:0]  bus_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // last command word, so a plain reset is not mistaken for a factory restore
  reg [7:0] last_cmd;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      last_cmd <= 8'h00;
    else if (psel && penable && pwrite && pready && paddr == 12'h000)
      last_cmd <= pwdata[7:0];
  // ==========================================================
  // bus timing and config relations
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_range: assert property (psel && penable && pready && paddr > 12'h028 |-> pslverr)
    else $error("unmapped access not refused");
  chk_baud_map: assert property ($stable(baud_code) [*2] |-> baud_rate ==
    (baud_code == 2'h0 ? 17'h0_2580 : baud_code == 2'h1 ? 17'h0_4B00 :
     baud_code == 2'h2 ? 17'h0_9600 : 17'h0_E100))
    else $error("baud rate does not match code");
  chk_addr_range: assert property (bus_addr >= 5'h01 && bus_addr <= 5'h1E)
    else $error("bus address outside legal range");
  chk_trigger_setup_cmd_cause: assert property (trigger_pulse |-> $past(cmd_term_seen))
    else $error("trigger without terminator");
  chk_trigger_setup_cmd_once: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse too long");
  chk_abort_cause: assert property (abort_pulse |-> $past(cmd_term_seen))
    else $error("abort without terminator");
  chk_factory_restore_cmd_zero: assert property (inst_reset_pulse && last_cmd == 8'h12 |->
    $past(output_at_zero) && $past(cmd_term_seen))
    else $error("factory restore while output not at zero");
  chk_term_apply: assert property ($changed(bus_term) |-> $past(cmd_term_seen))
    else $error("terminator changed before command end");
  chk_baud_cmd: assert property ($changed(baud_code) |-> $past(cmd_term_seen))
    else $error("baud code changed without command");
endmodule // rcsu_checker

bind rcsu_remote_command_status_unit rcsu_checker u_rcsu_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .cmd_term_seen(cmd_term_seen),
  .output_at_zero(output_at_zero), .trigger_pulse(trigger_pulse),
  .abort_pulse(abort_pulse), .inst_reset_pulse(inst_reset_pulse),
  .baud_code(baud_code), .baud_rate(baud_rate), .bus_term(bus_term), .bus_addr(bus_addr)
);

// [test/rcsu_inst_model.sv]
/*
  far-side model: terminator detector and pending-operation timer.
  assumes it watches the unit's apb lines to spot command writes.
*/
`timescale 1ns/100ps
module rcsu_inst_model (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb watch
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire        pready,
  input  wire [11:0] paddr,
  // bench control and instrument lines
  input  wire [7:0]  busy_len,
  output wire        cmd_term_seen,
  output wire        ops_busy
);
  reg  [1:0] tcnt;
  reg  [7:0] bcnt;
  wire       cmd_wr = psel & penable & pwrite & pready & (paddr == 12'h000);
  // ==========================================================
  // terminator trails the command word, so execution must wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 2'h0;
      bcnt <= 8'h00;
    end else if (cmd_wr) begin
      tcnt <= 2'h3;
      bcnt <= busy_len;
    end else begin
      tcnt <= tcnt - {1'b0, tcnt != 2'h0};
      bcnt <= bcnt - {7'h00, bcnt != 8'h00};
    end
  end
  assign cmd_term_seen = (tcnt == 2'h0);
  assign ops_busy      = (bcnt != 8'h00);
endmodule // rcsu_inst_model

// [test/rcsu_remote_command_status_unit_test.sv]
/*
  self-checking bench for the remote command and status unit.
  assumes the design, its constants header, checker and far-side model.
*/
`timescale 1ns/100ps
`include "rcsu_consts.vh"
module rcsu_remote_command_status_unit_test;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg         key_pressed = 1'b0, output_at_zero = 1'b0, stf = 1'b0;
  reg  [15:0] meas = 16'h0064;
  reg  [7:0]  op_det = 8'h00, op_cond = 8'h00, busy_len = 8'h00;
  wire [31:0] prdata, field_value;
  wire        pready, pslverr, cmd_term_seen, ops_busy, srq, trigger_pulse, abort_pulse;
  wire        inst_reset_pulse, bus_eoi_off, field_units;
  wire [1:0]  baud_code, bus_term;
  wire [16:0] baud_rate;
  wire [3:0]  screen_setup;
  wire [4:0]  bus_addr;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0, checks = 0, cycles = 0, trigger_setup_cmd_n = 0, abrt_n = 0, inst_n = 0;
  rcsu_remote_command_status_unit u_rcsu_remote_command_status_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_term_seen(cmd_term_seen), .ops_busy(ops_busy), .selftest_fail(stf),
    .key_pressed(key_pressed), .output_at_zero(output_at_zero), .meas_current(meas),
    .hw_err_det(8'h00), .op_err_det(op_det), .heat_err_det(8'h00), .op_err_cond(op_cond),
    .heat_err_cond(8'h00), .event_det(8'h00), .srq(srq), .trigger_pulse(trigger_pulse),
    .abort_pulse(abort_pulse), .inst_reset_pulse(inst_reset_pulse), .baud_code(baud_code),
    .baud_rate(baud_rate), .screen_setup(screen_setup), .bus_term(bus_term),
    .bus_eoi_off(bus_eoi_off), .bus_addr(bus_addr), .field_units(field_units),
    .field_value(field_value));
  rcsu_inst_model u_rcsu_inst_model (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .busy_len(busy_len), .cmd_term_seen(cmd_term_seen), .ops_busy(ops_busy));
  // ==========================================================
  // clock, pulse counting and hang guard
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    trigger_setup_cmd_n <= trigger_setup_cmd_n + trigger_pulse;
    abrt_n <= abrt_n + abort_pulse;
    inst_n <= inst_n + inst_reset_pulse;
    if (cycles == 20000) begin
      fail_count++;
      end_sim;
    end
  end
  task end_sim;
    begin
      if (fail_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (g !== e) begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // ==========================================================
  // access tasks: request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task cmd(input logic [7:0] c, input logic [31:0] a);
    begin
      apb(1'b1, 12'h004, a);
      apb(1'b1, 12'h000, {24'h00_0000, c});
      while (cmd_term_seen !== 1'b1) @(posedge pclk);
      repeat (2) @(posedge pclk);
    end
  endtask
  task qry(input logic [7:0] c);
    begin
      cmd(c, 32'h0000_0000);
      rd = 32'h0000_0000;
      while (rd[1] !== 1'b1) apb(1'b0, 12'h008, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000);
    end
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("bus_addr", 32'h0000_000C, bus_addr);
    apb(1'b0, 12'h02C, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, err);
    qry(`RCSU_C_KEYQ);
    chk("key first", 32'h0000_0001, rd);
    qry(`RCSU_C_KEYQ);
    chk("key idle", 32'h0000_0000, rd);
    key_pressed <= 1'b1;
    @(posedge pclk);
    key_pressed <= 1'b0;
    qry(`RCSU_C_KEYQ);
    chk("key hit", 32'h0000_0001, rd);
    qry(`RCSU_C_TSTQ);
    chk("selftest", 32'h0000_0000, rd);
    for (int i = 0; i < 4; i++) begin
      cmd(`RCSU_C_BAUD, i);
      qry(`RCSU_C_BAUDQ);
      chk("baud query", i, rd);
    end
    qry(`RCSU_C_IDNQ);
    chk("serial", 32'h0000_0001, rd);
    apb(1'b0, 12'h028, 32'h0000_0000);
    chk("identity", 32'h5A01_1010, rd);
    cmd(`RCSU_C_ESE, 32'h0000_0001);
    qry(`RCSU_C_ESEQ);
    chk("ese", 32'h0000_0001, rd);
    cmd(`RCSU_C_SRE, 32'h0000_0020);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("cfg masks", 32'h0000_2001, rd & 32'h0000_FFFF);
    busy_len <= 8'h28;
    cmd(`RCSU_C_OPC, 32'h0000_0000);
    busy_len <= 8'h00;
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("esr busy", 32'h0000_0000, rd);
    repeat (50) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("stb", 32'h0000_0060, rd);
    qry(`RCSU_C_STBQ);
    chk("stb query", 32'h0000_0060, rd);
    chk("srq", 32'h0000_0001, srq);
    cmd(`RCSU_C_CLS, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("stb cleared", 32'h0000_0000, rd);
    chk("abort", 32'h0000_0001, abrt_n);
    chk("baud kept", 32'h0000_0003, baud_code);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("esr cleared", 32'h0000_0000, rd);
    busy_len <= 8'h0A;
    qry(`RCSU_C_OPCQ);
    busy_len <= 8'h00;
    chk("opc query", 32'h0000_0001, rd);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("esr opc bit", 32'h0000_0000, rd & 32'h0000_0001);
    cmd(`RCSU_C_FACTORY_RESTORE_CMD, 32'h0000_0063);
    chk("factory_restore_cmd off zero", 32'h0000_0000, inst_n);
    output_at_zero <= 1'b1;
    cmd(`RCSU_C_FACTORY_RESTORE_CMD, 32'h0000_0062);
    chk("factory_restore_cmd bad key", 32'h0000_0000, inst_n);
    cmd(`RCSU_C_FACTORY_RESTORE_CMD, 32'h0000_0063);
    chk("factory_restore_cmd done", 32'h0000_0001, inst_n);
    chk("factory_restore_cmd baud", 32'h0000_0000, baud_code);
    cmd(`RCSU_C_SCREEN_SETUP_CMD, 32'h0000_000B);
    qry(`RCSU_C_DISPQ);
    chk("screen", 32'h0000_000B, rd);
    cmd(`RCSU_C_BUS, 32'h001E_0210);
    chk("bus", 32'h0000_00BE, {bus_term, bus_eoi_off, bus_addr});
    qry(`RCSU_C_BUSQ);
    chk("bus query", 32'h001E_0210, rd);
    cmd(`RCSU_C_BUS, 32'h001F_0000);
    cmd(`RCSU_C_BUS, 32'h0000_0000);
    chk("bus refused", 32'h0000_001E, bus_addr);
    cmd(`RCSU_C_RST, 32'h0000_0000);
    chk("rst screen", 32'h0000_0000, screen_setup);
    chk("rst bus", 32'h0000_001E, bus_addr);
    cmd(`RCSU_C_TRG, 32'h0000_0000);
    chk("trigger", 32'h0000_0001, trigger_setup_cmd_n);
    cmd(`RCSU_C_FIELD_CONSTANT_CMD, 32'h0001_0400);
    meas <= 16'h0003;
    repeat (3) @(posedge pclk);
    chk("field", 32'h0001_0C00, {field_units, field_value[15:0]});
    cmd(`RCSU_C_ERROR_MASK_CMD, 32'h0000_0100);
    op_cond <= 8'h01;
    op_det <= 8'h01;
    @(posedge pclk);
    op_det <= 8'h00;
    cmd(`RCSU_C_ERROR_CLEAR_CMD, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("err kept", 32'h0000_0004, rd & 32'h0000_0004);
    op_cond <= 8'h00;
    cmd(`RCSU_C_ERROR_CLEAR_CMD, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("err cleared", 32'h0000_0000, rd & 32'h0000_0004);
    stf <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("addr reset", 32'h0000_000C, bus_addr);
    qry(`RCSU_C_TSTQ);
    chk("selftest bad", 32'h0000_0001, rd);
    end_sim;
  end
endmodule // rcsu_remote_command_status_unit_test
